/* rtl/i2csa_pkg.sv */
// Summary of operation
// - All slave functions except general call; start/stop interrupts in the two slave modes with start/stop (S7SP, S10SP).
// - Standard mode slave with 7-bit and 10-bit addressing.
// - Four-bit mode field picks one of five I2C modes.
// - Nothing but the start/stop status bits operates unless port_enable is set.
// - Enabled I2C mode with both pins set as inputs drives pins open drain.
// - As slave transmitter the device drives its own data onto SDA.
// - On match or data byte: acknowledge and, in the same cycle, copy bit_shifter into buffer.
// - Every matched address or received data byte sets irq flag; load if buffer empty; ack if neither flag set.
// - Buffer read clears buffer-full; overflow cleared only by software write.
// - After enable wait for start, then shift eight bits.
// - Sample each data bit on rising SCL.
// - Compare shifter bits 7:1 to address on falling edge of eighth clock.
// - Match with flags clear: load, set full, ack, irq at ninth falling edge.
// - 10-bit first byte is 11110 A9 A8 then write direction bit.
// - Each 10-bit address byte sets irq, full, update-address, holds SCL low.
// - 10-bit read after repeated start: high byte sets irq and full.
// - Matched write address clears status read/write bit, loads address.
// - Irq per data byte; software clears flag and reads status.
// - Clock release control set releases SCL; clear stretches SCL low while in the ACK or TX state.
package i2csa_pkg;
  localparam logic [3:0] I2CSA_MODE_S7    = 4'h6;
  localparam logic [3:0] I2CSA_MODE_S10   = 4'h7;
  localparam logic [3:0] I2CSA_MODE_MFW   = 4'hB;
  localparam logic [3:0] I2CSA_MODE_S7SP  = 4'hE;
  localparam logic [3:0] I2CSA_MODE_S10SP = 4'hF;
  localparam logic [4:0] I2CSA_TEN_HDR    = 5'h1E;
  localparam int         I2CSA_BITS       = 8;
  localparam logic [7:0] I2CSA_RST_BYTE   = 8'h00;

  typedef enum logic [2:0] {
    I2CSA_IDLE  = 3'b000,
    I2CSA_ADDR  = 3'b001,
    I2CSA_ACK   = 3'b010,
    I2CSA_RX    = 3'b011,
    I2CSA_TX    = 3'b100,
    I2CSA_TXACK = 3'b101,
    I2CSA_WAIT  = 3'b110
  } i2csa_state_t;
endpackage : i2csa_pkg

/* rtl/i2csa_bus_if.sv */
`timescale 1ns/1ps
interface i2csa_bus_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport sync (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
  modport core (input  scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface : i2csa_bus_if

/* rtl/i2csa_sync.sv */
`timescale 1ns/1ps
module i2csa_sync
  import i2csa_pkg::*;
(
  input  wire logic ref_clk_i,  // Clock
  input  wire logic rst_n_i,    // Sync reset
  input  wire logic ce_i,       // Clock enable
  input  wire logic scl_i,      // Raw SCL
  input  wire logic sda_i,      // Raw SDA
  i2csa_bus_if.sync bus         // Clean bus view
);
  logic [1:0] scl_meta_r;
  logic [1:0] sda_meta_r;
  logic       scl_d_r;
  logic       sda_d_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      scl_meta_r <= 2'h3;
      sda_meta_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else if (ce_i) begin
      scl_meta_r <= {scl_meta_r[0], scl_i};
      sda_meta_r <= {sda_meta_r[0], sda_i};
      scl_d_r    <= scl_meta_r[1];
      sda_d_r    <= sda_meta_r[1];
    end
  end

  assign bus.scl       = scl_d_r;
  assign bus.sda       = sda_d_r;
  assign bus.scl_rise  = ce_i & scl_meta_r[1] & ~scl_d_r;
  assign bus.scl_fall  = ce_i & ~scl_meta_r[1] & scl_d_r;
  assign bus.start_det = ce_i & scl_meta_r[1] & scl_d_r & sda_d_r & ~sda_meta_r[1];
  assign bus.stop_det  = ce_i & scl_meta_r[1] & scl_d_r & ~sda_d_r & sda_meta_r[1];
endmodule : i2csa_sync

/* rtl/i2csa_flags.sv */
`timescale 1ns/1ps
module i2csa_flags
  import i2csa_pkg::*;
(
  input  wire logic ref_clk_i,  // Clock
  input  wire logic rst_n_i,    // Sync reset
  input  wire logic ce_i,       // Clock enable
  input  wire logic set_i,      // Hardware set
  input  wire logic clr_i,      // Software clear
  output logic      flag_o      // Sticky flag
);
  // Set beats a same-cycle clear so no event is lost
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      flag_o <= 1'b0;
    end else if (ce_i) begin
      flag_o <= set_i | (flag_o & ~clr_i);
    end
  end
endmodule : i2csa_flags

/* rtl/i2csa_slave.sv */
`timescale 1ns/1ps
module i2csa_slave
  import i2csa_pkg::*;
(
  input  wire logic       ref_clk_i,        // 40 MHz clock
  input  wire logic       rst_n_i,          // Sync reset, active low
  input  wire logic       ce_i,             // Clock enable
  input  wire logic       scl_i,            // SCL pin level
  output logic            scl_o,            // SCL drive value (always 0)
  output logic            scl_oe_o,         // SCL pulled low
  input  wire logic       sda_i,            // SDA pin level
  output logic            sda_o,            // SDA drive value (always 0)
  output logic            sda_oe_o,         // SDA pulled low
  input  wire logic       port_enable_i,    // Port enable
  input  wire logic [3:0] mode_select_i,    // Mode select field
  input  wire logic [1:0] pin_direction_i,  // Direction bits, 1 = input
  input  wire logic       clock_release_i,  // Clock release control level
  input  wire logic       clock_release_wr_i, // Write pulse setting release
  input  wire logic [7:0] slave_address_i,  // Address register value
  input  wire logic       addr_wr_i,        // Address register write pulse
  input  wire logic       buf_rd_i,         // Receive buffer read pulse
  input  wire logic [7:0] tx_data_i,        // Transmit byte
  input  wire logic       tx_wr_i,          // Transmit byte write pulse
  input  wire logic       ovf_clr_i,        // Overflow clear pulse
  input  wire logic       irq_clr_i,        // Irq flag clear pulse
  output logic [7:0]      rx_tx_buffer_o,   // Receive buffer
  output logic            buffer_full_o,    // Buffer full flag
  output logic            overflow_o,       // Receive overflow flag
  output logic            irq_flag_o,       // Port irq flag
  output logic            update_addr_o,    // Update address flag
  output logic            read_write_o,     // Status read/write bit
  output logic            data_addr_o,      // Last byte was data
  output logic            start_seen_o,     // Start seen status
  output logic            stop_seen_o,      // Stop seen status
  output logic            scl_hold_o        // SCL stretched
);
  i2csa_bus_if bus ();

  i2csa_sync u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .bus       (bus)
  );

  i2csa_state_t state_r, state_nxt;
  logic [7:0] shifter_r;
  logic [3:0] bitcnt_r;
  logic [7:0] buf_r;
  logic       ack_r;
  logic       ten_hi_r;
  logic       ten_ok_r;
  logic       hold_r;
  logic       rw_r;
  logic       da_r;
  logic       ua_r;
  logic       ss_r;
  logic       sp_r;
  logic       sda_drv_r;
  logic [7:0] tx_sh_r;
  logic       ovf_set;
  logic       irq_set;

  // Mode decode
  wire mode_s7   = (mode_select_i == I2CSA_MODE_S7) | (mode_select_i == I2CSA_MODE_S7SP);
  wire mode_s10  = (mode_select_i == I2CSA_MODE_S10) | (mode_select_i == I2CSA_MODE_S10SP);
  wire mode_sp   = (mode_select_i == I2CSA_MODE_S7SP) | (mode_select_i == I2CSA_MODE_S10SP);
  wire mode_mfw  = (mode_select_i == I2CSA_MODE_MFW);
  wire i2c_mode  = mode_s7 | mode_s10 | mode_mfw;
  wire active    = port_enable_i & i2c_mode;
  // Slave only listens with both pins released to it
  wire slave_on  = active & (mode_s7 | mode_s10) & (pin_direction_i == 2'h3);
  wire pins_od   = active & (pin_direction_i == 2'h3);

  wire byte_done = bus.scl_fall & (bitcnt_r == 4'(I2CSA_BITS));
  wire ninth_fall = bus.scl_fall & (bitcnt_r == 4'(I2CSA_BITS + 1));
  wire blocked   = buffer_full_o | overflow_o;

  // Address match, general call deliberately not answered
  wire hdr_ten   = (shifter_r[7:3] == I2CSA_TEN_HDR);
  wire gen_call  = (shifter_r[7:1] == 7'h00);
  wire m7        = mode_s7 & ~gen_call & (shifter_r[7:1] == slave_address_i[7:1]);
  wire m10_hi    = mode_s10 & hdr_ten & (shifter_r[2:1] == slave_address_i[2:1]);
  wire m10_lo    = mode_s10 & ten_hi_r & ~ten_ok_r & (shifter_r == slave_address_i);
  wire m10_rd    = mode_s10 & ten_ok_r & m10_hi & shifter_r[0];
  wire addr_hit  = m7 | m10_hi | m10_lo;
  wire is_read   = (m7 | m10_rd) & shifter_r[0];
  wire is_ten    = mode_s10 & (m10_hi | m10_lo) & ~m10_rd;

  // Load and ack decisions at end of an address or data byte
  wire byte_rx   = byte_done & ((state_r == I2CSA_ADDR & addr_hit) | state_r == I2CSA_RX);
  wire do_load   = byte_rx & ~buffer_full_o;
  wire do_ack    = byte_rx & ~blocked;
  assign ovf_set = byte_rx & buffer_full_o & (state_r == I2CSA_RX);
  assign irq_set = (ninth_fall & (state_r == I2CSA_ACK)) |
                   (mode_sp & (bus.start_det | bus.stop_det) & active);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      I2CSA_IDLE:  state_nxt = state_r;
      I2CSA_ADDR:  if (byte_done) begin
                     state_nxt = addr_hit ? I2CSA_ACK : I2CSA_IDLE;
                   end
      I2CSA_ACK:   if (ninth_fall) begin
                     // Low address byte still to come after a 10-bit header
                     state_nxt = (rw_r & ~da_r) ? I2CSA_TX :
                                 ((ten_hi_r & ~ten_ok_r) ? I2CSA_ADDR : I2CSA_RX);
                   end
      I2CSA_RX:    if (byte_done) begin
                     state_nxt = I2CSA_ACK;
                   end
      I2CSA_TX:    if (byte_done) begin
                     state_nxt = I2CSA_TXACK;
                   end
      I2CSA_TXACK: if (ninth_fall) begin
                     state_nxt = bus.sda ? I2CSA_IDLE : I2CSA_TX;
                   end
      I2CSA_WAIT:  state_nxt = state_r;
      default:     state_nxt = I2CSA_IDLE;
    endcase
    if (bus.start_det & slave_on) begin
      state_nxt = I2CSA_ADDR;
    end else if (bus.stop_det | ~slave_on) begin
      state_nxt = I2CSA_IDLE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      state_r <= I2CSA_IDLE;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // Bit counter and shifter; count restarts at 1 on the rise after the ninth clock
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      bitcnt_r  <= 4'h0;
      shifter_r <= I2CSA_RST_BYTE;
    end else if (ce_i) begin
      if (bus.start_det) begin
        bitcnt_r <= 4'h0;
      end else if (bus.scl_rise) begin
        bitcnt_r  <= (bitcnt_r == 4'(I2CSA_BITS + 1)) ? 4'h1 : bitcnt_r + 4'h1;
        if (bitcnt_r != 4'(I2CSA_BITS)) begin
          shifter_r <= {shifter_r[6:0], bus.sda};
        end
      end
    end
  end

  // Buffer, ack latch and status bits
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      buf_r    <= I2CSA_RST_BYTE;
      ack_r    <= 1'b0;
      rw_r     <= 1'b0;
      da_r     <= 1'b0;
      ten_hi_r <= 1'b0;
      ten_ok_r <= 1'b0;
      ss_r     <= 1'b0;
      sp_r     <= 1'b0;
    end else if (ce_i) begin
      if (do_load) begin
        buf_r <= shifter_r;
      end
      if (byte_done & (state_r == I2CSA_ADDR | state_r == I2CSA_RX)) begin
        ack_r <= do_ack;
      end
      if (byte_done & state_r == I2CSA_ADDR & addr_hit) begin
        rw_r     <= is_read;
        da_r     <= 1'b0;
        ten_hi_r <= m10_hi & ~m10_rd;
        ten_ok_r <= m10_lo | (ten_ok_r & m10_rd);
      end else if (byte_done & state_r == I2CSA_RX) begin
        da_r <= 1'b1;
      end
      if (bus.start_det) begin
        ss_r <= 1'b1;
        sp_r <= 1'b0;
      end else if (bus.stop_det) begin
        sp_r     <= 1'b1;
        ss_r     <= 1'b0;
        ten_ok_r <= 1'b0;
      end
    end
  end

  // Stretch after 10-bit address bytes and after a read address, before the first transmit byte
  logic is_ten_r;
  // Data bytes never set hold_r, even inside a 10-bit session
  wire ten_ack  = ninth_fall & state_r == I2CSA_ACK & is_ten_r & ~da_r;
  wire hold_set = ten_ack |
                  (ninth_fall & state_r == I2CSA_ACK & rw_r & ~da_r);
  wire hold_clr = (ua_r & addr_wr_i) | (clock_release_wr_i & clock_release_i);
  wire hold_clr_n = ~(state_r == I2CSA_TX | state_r == I2CSA_ACK | hold_r);

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      is_ten_r <= 1'b0;
      ua_r     <= 1'b0;
      hold_r   <= 1'b0;
    end else if (ce_i) begin
      if (byte_done & state_r == I2CSA_ADDR) begin
        is_ten_r <= is_ten;
      end
      ua_r   <= ten_ack | (ua_r & ~addr_wr_i);
      hold_r <= slave_on & (hold_set | (hold_r & ~hold_clr));
    end
  end

  // Transmit shifter, loaded by software while clock is held
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      tx_sh_r   <= I2CSA_RST_BYTE;
      sda_drv_r <= 1'b0;
    end else if (ce_i) begin
      if (tx_wr_i) begin
        tx_sh_r <= tx_data_i;
      end else if (bus.scl_fall & state_r == I2CSA_TX & bitcnt_r != 4'h0) begin
        tx_sh_r <= {tx_sh_r[6:0], 1'b1};
      end
      if (bus.scl_fall) begin
        sda_drv_r <= (byte_done & do_ack) |
                     ((state_nxt == I2CSA_TX) & ~(byte_done | ninth_fall ? tx_sh_r[7] :
                      tx_sh_r[6]));
      end else if (~slave_on | bus.stop_det) begin
        sda_drv_r <= 1'b0;
      end
    end
  end

  i2csa_flags u_bf (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .set_i     (do_load),
    .clr_i     (buf_rd_i),
    .flag_o    (buffer_full_o)
  );

  i2csa_flags u_ov (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .set_i     (ovf_set),
    .clr_i     (ovf_clr_i),
    .flag_o    (overflow_o)
  );

  i2csa_flags u_if (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .set_i     (irq_set),
    .clr_i     (irq_clr_i),
    .flag_o    (irq_flag_o)
  );

  // Pins only driven in open-drain configuration
  assign scl_o          = 1'b0;
  assign sda_o          = 1'b0;
  assign scl_oe_o       = pins_od & slave_on & (hold_r | ~clock_release_i & ~hold_clr_n);
  assign sda_oe_o       = pins_od & slave_on & sda_drv_r;
  assign rx_tx_buffer_o = buf_r;
  assign update_addr_o  = ua_r;
  assign read_write_o   = rw_r;
  assign data_addr_o    = da_r;
  assign start_seen_o   = ss_r;
  assign stop_seen_o    = sp_r;
  assign scl_hold_o     = scl_oe_o;

  a_ack_when_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    byte_rx & blocked |-> ##1 !ack_r)
    else $error("ack given while blocked");
  a_load_on_match: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    do_load & ce_i |=> buffer_full_o && rx_tx_buffer_o == $past(shifter_r))
    else $error("buffer not loaded");
  a_irq_ninth_edge: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i & ninth_fall & state_r == I2CSA_ACK |=> irq_flag_o)
    else $error("irq not set on ninth fall");
  a_ovf_sticky: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    overflow_o & !ovf_clr_i |=> overflow_o)
    else $error("overflow dropped");
  a_bf_read_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i & buf_rd_i & !do_load |=> !buffer_full_o)
    else $error("buffer full not cleared");
  a_miss_no_ack: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    byte_done & state_r == I2CSA_ADDR & !addr_hit & ce_i |=> state_r == I2CSA_IDLE)
    else $error("mismatch not ignored");
  a_disabled_quiet: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !port_enable_i |-> !scl_oe_o && !sda_oe_o)
    else $error("pins driven while disabled");
  a_ua_holds_scl: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ua_r & pins_od & slave_on & hold_r |-> scl_oe_o)
    else $error("clock not held for address update");
  c_addr_ack: cover property (@(posedge ref_clk_i) do_ack);
  c_overflow: cover property (@(posedge ref_clk_i) ovf_set);
  c_ten_bit:  cover property (@(posedge ref_clk_i) ua_r);
  c_transmit: cover property (@(posedge ref_clk_i) state_r == I2CSA_TX);
endmodule : i2csa_slave

/* test/i2csa_master_model.sv */
`timescale 1ns/1ps
module i2csa_master_model (
  input  wire logic clk_i,     // Bench clock
  input  wire logic scl_i,     // SCL wire level
  input  wire logic sda_i,     // SDA wire level
  output logic      scl_oe_o,  // Pull SCL low
  output logic      sda_oe_o,  // Pull SDA low
  output logic      stuck_o    // Slave held SCL too long
);
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    stuck_o  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // Release SCL, then wait out any stretching by the slave
  task automatic rise();
    int k;
    scl_oe_o <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (scl_i !== 1'b1 && k < 4000);
    if (k >= 4000) stuck_o <= 1'b1;
  endtask : rise

  task automatic start();
    sda_oe_o <= 1'b0;
    rise();
    tick(4);
    sda_oe_o <= 1'b1;
    tick(4);
    scl_oe_o <= 1'b1;
    tick(2);
  endtask : start

  // SDA moves only while SCL is low, so no false start or stop
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_oe_o <= ~b[i];
      tick(2);
      rise();
      tick(4);
      scl_oe_o <= 1'b1;
      tick(2);
    end
    sda_oe_o <= 1'b0;
    tick(2);
    rise();
    tick(2);
    ack = ~sda_i;
    tick(2);
    scl_oe_o <= 1'b1;
    tick(2);
  endtask : send

  task automatic stop();
    sda_oe_o <= 1'b1;
    tick(2);
    rise();
    tick(4);
    sda_oe_o <= 1'b0;
    tick(4);
  endtask : stop
endmodule : i2csa_master_model

/* test/tb_top.sv */
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tb_top;
  import i2csa_pkg::*;
  typedef struct packed {
    logic       en;
    logic [1:0] dir;
    logic [3:0] mode;
    logic [7:0] addr;
    logic [7:0] dat;
    logic       ack;
    logic       full;
    logic [7:0] buf_v;
  } i2csa_row_t;
  i2csa_row_t rows [10] = '{
    '{1'b1, 2'h3, I2CSA_MODE_S7,    8'h52, 8'h52, 1'b1, 1'b1, 8'h52},
    '{1'b1, 2'h3, I2CSA_MODE_S7,    8'h52, 8'h54, 1'b0, 1'b0, 8'h00},
    '{1'b1, 2'h3, I2CSA_MODE_S7SP,  8'hFE, 8'hFE, 1'b1, 1'b1, 8'hFE},
    '{1'b1, 2'h3, I2CSA_MODE_S7,    8'h00, 8'h00, 1'b0, 1'b0, 8'h00},
    '{1'b1, 2'h3, I2CSA_MODE_MFW,   8'h52, 8'h52, 1'b0, 1'b0, 8'h00},
    '{1'b0, 2'h3, I2CSA_MODE_S7,    8'h52, 8'h52, 1'b0, 1'b0, 8'h00},
    '{1'b1, 2'h1, I2CSA_MODE_S7,    8'h52, 8'h52, 1'b0, 1'b0, 8'h00},
    '{1'b1, 2'h3, I2CSA_MODE_S10,   8'hF4, 8'hF4, 1'b1, 1'b1, 8'hF4},
    '{1'b1, 2'h3, I2CSA_MODE_S10SP, 8'hF4, 8'hF4, 1'b1, 1'b1, 8'hF4},
    '{1'b1, 2'h3, I2CSA_MODE_S10,   8'hF4, 8'hF6, 1'b0, 1'b0, 8'h00}
  };
  logic       ref_clk  = 1'b0;
  logic       rst_n    = 1'b0;
  logic       port_en  = 1'b0;
  logic [3:0] mode     = I2CSA_MODE_S7;
  logic [1:0] pin_dir  = 2'h3;
  logic [7:0] slv_addr = 8'h00;
  logic       addr_wr  = 1'b0;
  logic       buf_rd   = 1'b0;
  logic       ovf_clr  = 1'b0;
  logic       irq_clr  = 1'b0;
  logic       scl_oe, sda_oe, m_scl_oe, m_sda_oe, stuck, ack;
  logic       full, ovf, irq, upd, rw, hold;
  logic [7:0] rx_buf;
  int         fail_count = 0;
  int         compares   = 0;
  wire        scl_w = ~(scl_oe | m_scl_oe);
  wire        sda_w = ~(sda_oe | m_sda_oe);

  always #12.5 ref_clk = ~ref_clk;

  i2csa_slave dut_u (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .ce_i(1'b1),
    .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe),
    .port_enable_i(port_en), .mode_select_i(mode), .pin_direction_i(pin_dir),
    .clock_release_i(1'b1), .clock_release_wr_i(1'b0),
    .slave_address_i(slv_addr), .addr_wr_i(addr_wr), .buf_rd_i(buf_rd),
    .tx_data_i(8'h00), .tx_wr_i(1'b0), .ovf_clr_i(ovf_clr), .irq_clr_i(irq_clr),
    .rx_tx_buffer_o(rx_buf), .buffer_full_o(full), .overflow_o(ovf),
    .irq_flag_o(irq), .update_addr_o(upd), .read_write_o(rw),
    .data_addr_o(), .start_seen_o(), .stop_seen_o(), .scl_hold_o(hold)
  );

  i2csa_master_model mst_u (
    .clk_i(ref_clk), .scl_i(scl_w), .sda_i(sda_w),
    .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe), .stuck_o(stuck)
  );

  task automatic summarize();
    if (fail_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  task automatic do_reset();
    rst_n <= 1'b0;
    tick(5);
    rst_n <= 1'b1;
    tick(1);
  endtask : do_reset

  // Software pulses: {overflow clear, irq clear, buffer read}
  task automatic pulse(input logic [2:0] sel);
    {ovf_clr, irq_clr, buf_rd} <= sel;
    tick(1);
    {ovf_clr, irq_clr, buf_rd} <= 3'h0;
    tick(2);
  endtask : pulse

  // Firmware side after each of the two 10-bit address bytes
  task automatic respond(input logic [7:0] nxt, input logic [7:0] exp_buf);
    int k;
    k = 0;
    while (upd !== 1'b1 && k < 2000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 2000) begin
      fail_count++;
      summarize();
    end
    tick(2);
    `CHK(hold, 1'b1)
    `CHK(scl_w, 1'b0)
    `CHK(irq, 1'b1)
    `CHK(full, 1'b1)
    `CHK(rx_buf, exp_buf)
    slv_addr <= nxt;
    addr_wr <= 1'b1;
    tick(1);
    addr_wr <= 1'b0;
    pulse(3'h3);
    `CHK(upd, 1'b0)
    `CHK(hold, 1'b0)
    `CHK(full, 1'b0)
    `CHK(irq, 1'b0)
  endtask : respond

  initial begin
    do_reset();
    foreach (rows[i]) begin
      port_en  <= rows[i].en;
      pin_dir  <= rows[i].dir;
      mode     <= rows[i].mode;
      slv_addr <= rows[i].addr;
      do_reset();
      mst_u.start();
      mst_u.send(rows[i].dat, ack);
      tick(6);
      `CHK(ack, rows[i].ack)
      `CHK(full, rows[i].full)
      `CHK(rx_buf, rows[i].buf_v)
      if (rows[i].mode != I2CSA_MODE_MFW) `CHK(irq, rows[i].full)
      if (rows[i].full) `CHK(rw, 1'b0)
    end
    port_en  <= 1'b1;
    pin_dir  <= 2'h3;
    mode     <= I2CSA_MODE_S7;
    slv_addr <= 8'h52;
    do_reset();
    mst_u.start();
    mst_u.send(8'h52, ack);
    mst_u.send(8'hA5, ack);
    tick(6);
    `CHK(ack, 1'b0)
    `CHK(ovf, 1'b1)
    `CHK(rx_buf, 8'h52)
    `CHK(irq, 1'b1)
    pulse(3'h3);
    `CHK(full, 1'b0)
    `CHK(ovf, 1'b1)
    mst_u.send(8'h3C, ack);
    tick(6);
    `CHK(ack, 1'b0)
    `CHK(rx_buf, 8'h3C)
    `CHK(irq, 1'b1)
    pulse(3'h7);
    `CHK(ovf, 1'b0)
    `CHK(irq, 1'b0)
    mst_u.send(8'h81, ack);
    tick(6);
    `CHK(ack, 1'b1)
    `CHK(rx_buf, 8'h81)
    `CHK(full, 1'b1)
    mst_u.stop();
    mode     <= I2CSA_MODE_S10;
    slv_addr <= 8'hF4;
    do_reset();
    mst_u.start();
    fork
      mst_u.send(8'hF4, ack); // first byte as write
      respond(8'hA5, 8'hF4);
    join
    `CHK(ack, 1'b1)
    fork
      mst_u.send(8'hA5, ack);
      respond(8'hF4, 8'hA5);
    join
    `CHK(ack, 1'b1)
    mst_u.send(8'h5A, ack);
    tick(6);
    `CHK(rx_buf, 8'h5A)
    `CHK(irq, 1'b1)
    mst_u.stop();
    `CHK(stuck, 1'b0)
    summarize();
  end
endmodule : tb_top
